// ===== rtl/adc_test_pattern_gain_power_ctrl.sv
// Configuration registers, test patterns, gain and power control of a quad converter
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RULE1] Per-channel 4-bit selector, active only with test enable; 0 normal, 1 zeros, 2 ones.
// [RULE2] Code 0011 alternates each sample between the two alternating-bit words.
// [RULE3] Code 0100 ramps by one per sample from 0 to 4095.
// [RULE4] Code 0101 outputs the shared 12-bit custom word.
// [RULE5] Code 0110 outputs AAA hex constantly.
// [RULE6] Code 1000 outputs a pseudo-random sequence stepped each sample.
// [RULE7] Code 1001 repeats an eight-point sine; other codes are unused.
// [RULE8] Per-channel 4-bit gain in 0x0c/0x0d, applied only while its enable is set.
// [RULE9] Gain code selects 0 to 6 dB in 0.5 dB steps.
// [RULE10] Register 0x0e holds custom word bits 11:4, shared by all channels.
// [RULE11] Upper nibble of 0x0f holds custom word bits 3:0; lower bits zero.
// [RULE12] Software sets low-speed bit 7 of 0x13 below 25 MSPS only.
// [RULE13] Bits 7..4 of 0x15 power down channels A..D.
// [RULE14] Bit 3 of 0x15 puts all four converters in standby.
// [RULE15] Bit 2 of 0x15 puts the whole device into power-down.
// [RULE16] Bit 0 of 0x15 maps pin high to power-down (0) or standby (1).
// [RULE17] Bits 7:6 of 0x27 pick bypass, divide by 1, 2 or 4.
// [RULE18] One global test enable switches outputs to the selected patterns.
// [RULE19] PRBS uses fixed polynomial x^15+x^14+1, all-ones seed, one step per sample.
// [RULE20] Reserved bits are written zero, ignored, and read back as zero.
module adc_test_pattern_gain_power_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] convA,
  input wire logic [11:0] convB,
  input wire logic [11:0] convC,
  input wire logic [11:0] convD,
  input wire logic sleepPin,
  output logic [11:0] dataA,
  output logic [11:0] dataB,
  output logic [11:0] dataC,
  output logic [11:0] dataD,
  output logic dataValid,
  output logic [3:0] chanSleep,
  output logic convStandby,
  output logic chipSleep,
  output logic lowSpeed,
  output logic [7:0] linkTest
);

  // Local counts
  localparam int NS = adc_cfg_pkg::NUM_SLOTS;
  localparam int NC = adc_cfg_pkg::NUM_CH;

  // Register storage and bus state
  logic [7:0] cfg_q [NS];
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Decode
  logic [NS-1:0] slotHit;
  logic statusHit;
  logic mapped;
  logic setupPhase;
  logic wrDone;
  logic softReset;
  logic [7:0] rdByte;
  logic [7:0] statusByte;

  // Decoded controls
  logic testEn;
  logic [11:0] userWord;
  logic [7:0] powerReg;
  logic chipSleepNow;
  logic standbyNow;
  logic [3:0] chanSleepNow;

  // Sample-rate divider
  logic [1:0] divCnt_q;
  logic [1:0] divLast;
  logic sampleEn;

  // Channel data
  logic [11:0] convIn [NC];
  logic [11:0] pattern [NC];
  logic [11:0] gained [NC];
  logic [11:0] data_d [NC];
  logic [11:0] data_q [NC];
  logic dataValid_q;

  // Registered status outputs
  logic [3:0] chanSleep_q;
  logic convStandby_q;
  logic chipSleep_q;
  logic lowSpeed_q;
  logic [7:0] linkTest_q;

  // Raw samples per channel
  assign convIn[0] = convA;
  assign convIn[1] = convB;
  assign convIn[2] = convC;
  assign convIn[3] = convD;

  // Address decode: aligned word, byte address is four times the index
  // Misaligned means refused
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++)
    begin : g_decode
      assign slotHit[gi] = (paddr[1:0] == 2'b00)
                        && (paddr[11:2] == {2'b00, adc_cfg_pkg::SLOT_IDX[gi]});
    end
  endgenerate

  // Status hit and bus phases
  assign statusHit = (paddr[1:0] == 2'b00) && (paddr[11:2] == {2'b00, adc_cfg_pkg::IDX_STATUS});
  assign mapped = (|slotHit) || statusHit;
  assign setupPhase = psel && !penable;
  assign wrDone = psel && penable && pready_q && pwrite && !pslverr_q;

  // Self-clearing reset bit: acts at the write edge, never stored
  assign softReset = wrDone && slotHit[adc_cfg_pkg::SLOT_CTRL]
                  && pwdata[adc_cfg_pkg::SOFT_RESET_BIT];

  // Register bank, one flop group per slot; reserved bits forced low
  // Soft reset beats a write
  generate
    for (gi = 0; gi < NS; gi++)
    begin : g_regs
      always_ff @(posedge clk)
      begin
        if (!rst_n || softReset)
          cfg_q[gi] <= adc_cfg_pkg::REG_RESET;
        else if (wrDone && slotHit[gi])
          cfg_q[gi] <= pwdata[7:0] & adc_cfg_pkg::SLOT_MASK[gi]; // [RULE20]
      end
    end
  endgenerate

  // Status byte: live block state
  // Phase, sleep, standby, channels
  assign statusByte = {divCnt_q, chipSleep_q, convStandby_q, chanSleep_q};

  // Read mux
  always_comb
  begin
    rdByte = 8'h00;
    for (int i = 0; i < NS; i++)
    begin
      if (slotHit[i])
        rdByte = cfg_q[i];
    end
    if (statusHit)
      rdByte = statusByte;
  end

  // APB answer: one wait-free access phase after each setup
  // Errors still complete
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (setupPhase)
    begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= (!pwrite && mapped) ? {24'h00_0000, rdByte} : 32'h0000_0000;
    end
    else
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Bus answer from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Field extraction
  // Reserved bits stored as zero
  assign testEn = cfg_q[adc_cfg_pkg::SLOT_CTRL][adc_cfg_pkg::TEST_EN_BIT]; // [RULE18]
  assign userWord = {cfg_q[adc_cfg_pkg::SLOT_USER_HI], // [RULE10]
                     cfg_q[adc_cfg_pkg::SLOT_USER_LO][7:4]}; // [RULE11]
  assign powerReg = cfg_q[adc_cfg_pkg::SLOT_POWER];

  // Power state: register bits plus the pin, routed by its function bit
  // Pin never clears a sleep
  assign chipSleepNow = powerReg[adc_cfg_pkg::CHIP_SLEEP_BIT] // [RULE15]
                     || (sleepPin && !powerReg[adc_cfg_pkg::PIN_FUNC_BIT]); // [RULE16]
  assign standbyNow = powerReg[adc_cfg_pkg::STANDBY_BIT] // [RULE14]
                   || (sleepPin && powerReg[adc_cfg_pkg::PIN_FUNC_BIT]); // [RULE16]

  // Own bit or device sleep
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_sleep
      assign chanSleepNow[gi] = powerReg[adc_cfg_pkg::SLEEP_A_BIT - gi] || chipSleepNow; // [RULE13]
    end
  endgenerate

  // Divider period from the clock divider field
  // Bypass ticks as divide-by-1
  always_comb
  begin
    case (adc_cfg_pkg::div_t'(cfg_q[adc_cfg_pkg::SLOT_DIV][adc_cfg_pkg::DIV_MSB:adc_cfg_pkg::DIV_LSB]))
      adc_cfg_pkg::DIV_BYPASS: divLast = 2'd0; // [RULE17]
      adc_cfg_pkg::DIV_BY_1: divLast = 2'd0; // [RULE17]
      adc_cfg_pkg::DIV_BY_2: divLast = 2'd1; // [RULE17]
      adc_cfg_pkg::DIV_BY_4: divLast = 2'd3; // [RULE17]
      default: divLast = 2'd0;
    endcase
  end

  // Sample enable counter
  // Shorter period restarts it
  always_ff @(posedge clk)
  begin
    if (!rst_n || softReset)
      divCnt_q <= 2'd0;
    else if (divCnt_q >= divLast)
      divCnt_q <= 2'd0;
    else
      divCnt_q <= divCnt_q + 2'd1;
  end

  // Tick at count zero
  assign sampleEn = (divCnt_q == 2'd0);

  // Per-channel pattern, gain and output selection
  // First channel in bits 7:4
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_chan
      logic [3:0] sel;
      logic [3:0] gainCode;
      logic gainOn;

      assign sel = (gi % 2 == 0) ? cfg_q[adc_cfg_pkg::SLOT_SEL_AB + gi / 2][7:4]
                                 : cfg_q[adc_cfg_pkg::SLOT_SEL_AB + gi / 2][3:0]; // [RULE1]
      assign gainCode = (gi % 2 == 0) ? cfg_q[adc_cfg_pkg::SLOT_GAIN_AB + gi / 2][7:4]
                                      : cfg_q[adc_cfg_pkg::SLOT_GAIN_AB + gi / 2][3:0]; // [RULE8]
      assign gainOn = cfg_q[adc_cfg_pkg::SLOT_GAIN_ON_A + gi][adc_cfg_pkg::GAIN_ON_BIT];

      // Runs free, channels in step
      test_pattern_gen u_pattern (
        .clk(clk),
        .rst_n(rst_n),
        .clear(softReset),
        .sampleEn(sampleEn),
        .sel(sel),
        .userWord(userWord),
        .pattern(pattern[gi])
      );

      // Gain on raw samples only
      digital_gain u_gain (
        .sampleIn(convIn[gi]),
        .code(gainCode),
        .sampleOut(gained[gi])
      );

      // Sleep or standby mutes; test mode replaces data; else optional gain
      always_comb
      begin
        if (chanSleepNow[gi] || standbyNow)
          data_d[gi] = 12'h000;
        else if (testEn && (sel != adc_cfg_pkg::PAT_NORMAL)) // [RULE18]
          data_d[gi] = pattern[gi];
        else if (gainOn)
          data_d[gi] = gained[gi]; // [RULE8]
        else
          data_d[gi] = convIn[gi];
      end

      // Output word updates once per sample
      // Word holds between ticks
      always_ff @(posedge clk)
      begin
        if (!rst_n || softReset)
          data_q[gi] <= 12'h000;
        else if (sampleEn)
          data_q[gi] <= data_d[gi];
      end
    end
  endgenerate

  // Channel words to pins
  assign dataA = data_q[0];
  assign dataB = data_q[1];
  assign dataC = data_q[2];
  assign dataD = data_q[3];

  // Sample strobe, one cycle per update
  // High in the same cycle as each new word
  always_ff @(posedge clk)
  begin
    if (!rst_n || softReset)
      dataValid_q <= 1'b0;
    else
      dataValid_q <= sampleEn;
  end

  // Strobe to its pin
  assign dataValid = dataValid_q;

  // Registered power and mode outputs
  // One cycle behind inputs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      chanSleep_q <= 4'h0;
      convStandby_q <= 1'b0;
      chipSleep_q <= 1'b0;
      lowSpeed_q <= 1'b0;
      linkTest_q <= 8'h00;
    end
    else
    begin
      chanSleep_q <= chanSleepNow; // [RULE13]
      convStandby_q <= standbyNow; // [RULE14]
      chipSleep_q <= chipSleepNow; // [RULE15]
      lowSpeed_q <= cfg_q[adc_cfg_pkg::SLOT_SLOW][adc_cfg_pkg::SLOW_BIT]; // [RULE12]
      linkTest_q <= cfg_q[adc_cfg_pkg::SLOT_LINK];
    end
  end

  // Power and mode outputs to pins
  assign chanSleep = chanSleep_q;
  assign convStandby = convStandby_q;
  assign chipSleep = chipSleep_q;
  assign lowSpeed = lowSpeed_q;
  assign linkTest = linkTest_q;

endmodule // adc_test_pattern_gain_power_ctrl

`default_nettype wire

// ===== rtl/adc_cfg_pkg.sv
// Shared constants and types for the converter configuration block
`default_nettype none
package adc_cfg_pkg;

  // Geometry
  localparam int NUM_CH = 4;
  localparam int DATA_W = 12;
  localparam int ADDR_W = 12;
  localparam int NUM_SLOTS = 15;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_GAIN_ON_A = 8'h02;
  localparam logic [7:0] IDX_GAIN_ON_B = 8'h03;
  localparam logic [7:0] IDX_GAIN_ON_C = 8'h04;
  localparam logic [7:0] IDX_GAIN_ON_D = 8'h05;
  localparam logic [7:0] IDX_TEST_CTRL = 8'h06;
  localparam logic [7:0] IDX_TEST_SEL_CH_A_B = 8'h0a;
  localparam logic [7:0] IDX_TEST_SEL_CH_C_D = 8'h0b;
  localparam logic [7:0] IDX_GAIN_CH_A_B = 8'h0c;
  localparam logic [7:0] IDX_GAIN_CH_C_D = 8'h0d;
  localparam logic [7:0] IDX_USER_WORD_HIGH = 8'h0e;
  localparam logic [7:0] IDX_USER_WORD_LOW = 8'h0f;
  localparam logic [7:0] IDX_SLOW_RATE_SELECT = 8'h13;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h15;
  localparam logic [7:0] IDX_SAMPLE_CLOCK_DIVIDER = 8'h27;
  localparam logic [7:0] IDX_LINK_TEST_CONTROL = 8'h2a;
  localparam logic [7:0] IDX_STATUS = 8'h40;

  // Storage slots, in the order of the tables below
  localparam int SLOT_GAIN_ON_A = 0;
  localparam int SLOT_CTRL = 4;
  localparam int SLOT_SEL_AB = 5;
  localparam int SLOT_GAIN_AB = 7;
  localparam int SLOT_USER_HI = 9;
  localparam int SLOT_USER_LO = 10;
  localparam int SLOT_SLOW = 11;
  localparam int SLOT_POWER = 12;
  localparam int SLOT_DIV = 13;
  localparam int SLOT_LINK = 14;

  localparam logic [7:0] SLOT_IDX [NUM_SLOTS] = '{
    IDX_GAIN_ON_A, IDX_GAIN_ON_B, IDX_GAIN_ON_C, IDX_GAIN_ON_D, IDX_TEST_CTRL,
    IDX_TEST_SEL_CH_A_B, IDX_TEST_SEL_CH_C_D, IDX_GAIN_CH_A_B, IDX_GAIN_CH_C_D,
    IDX_USER_WORD_HIGH, IDX_USER_WORD_LOW, IDX_SLOW_RATE_SELECT,
    IDX_POWER_CONTROL, IDX_SAMPLE_CLOCK_DIVIDER, IDX_LINK_TEST_CONTROL};

  // Writable bits per slot; all others are reserved and read zero
  localparam logic [7:0] SLOT_MASK [NUM_SLOTS] = '{
    8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hf0, 8'h80, 8'hfd, 8'hc0, 8'hff};

  localparam logic [7:0] REG_RESET = 8'h00;

  // Field positions
  localparam int GAIN_ON_BIT = 1;
  localparam int TEST_EN_BIT = 1;
  localparam int SOFT_RESET_BIT = 0;
  localparam int SLOW_BIT = 7;
  localparam int SLEEP_A_BIT = 7;
  localparam int STANDBY_BIT = 3;
  localparam int CHIP_SLEEP_BIT = 2;
  localparam int PIN_FUNC_BIT = 0;
  localparam int DIV_MSB = 7;
  localparam int DIV_LSB = 6;

  // Pattern selector codes
  typedef enum logic [3:0] {
    PAT_NORMAL = 4'b0000,
    PAT_ZEROS = 4'b0001,
    PAT_ONES = 4'b0010,
    PAT_TOGGLE = 4'b0011,
    PAT_RAMP = 4'b0100,
    PAT_USER = 4'b0101,
    PAT_DESKEW = 4'b0110,
    PAT_PRBS = 4'b1000,
    PAT_SINE = 4'b1001
  } pattern_t;

  // Clock divider settings
  typedef enum logic [1:0] {
    DIV_BYPASS = 2'b00,
    DIV_BY_1 = 2'b01,
    DIV_BY_2 = 2'b10,
    DIV_BY_4 = 2'b11
  } div_t;

  // Fixed pattern words
  localparam logic [11:0] TOGGLE_WORD_A = 12'haaa;
  localparam logic [11:0] TOGGLE_WORD_B = 12'h555;
  localparam logic [11:0] DESKEW_WORD = 12'haaa;
  localparam logic [11:0] ALL_ONES = 12'hfff;
  localparam logic [11:0] RAMP_LAST = 12'hfff;

  // PRBS: x^15 + x^14 + 1, all-ones seed
  localparam int PRBS_W = 15;
  localparam logic [14:0] PRBS_SEED = 15'h7fff;

  localparam logic [11:0] SINE_TABLE [8] = '{
    12'h000, 12'h257, 12'h800, 12'hda8, 12'hfff, 12'hda8, 12'h800, 12'h257};

  // Gain factors in units of 1/1024, 0.5 dB per code
  localparam int GAIN_FRAC = 10;
  localparam logic [3:0] GAIN_MAX_CODE = 4'hc;
  localparam logic [11:0] GAIN_TABLE [13] = '{
    12'h400, 12'h43d, 12'h47d, 12'h4c1, 12'h509, 12'h556, 12'h5a6,
    12'h5fc, 12'h657, 12'h6b7, 12'h71e, 12'h789, 12'h7fb};

endpackage

`default_nettype wire

// ===== rtl/test_pattern_gen.sv
// One channel's test pattern generator
`timescale 1ns/100ps
`default_nettype none

module test_pattern_gen (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic sampleEn,
  input wire logic [3:0] sel,
  input wire logic [11:0] userWord,
  output logic [11:0] pattern
);

  logic [11:0] ramp_q;
  logic toggle_q;
  logic [14:0] prbs_q;
  logic [2:0] sineIdx_q;

  // Free-running sequences, one step per sample
  always_ff @(posedge clk)
  begin
    if (!rst_n || clear)
    begin
      ramp_q <= 12'h000;
      toggle_q <= 1'b0;
      prbs_q <= adc_cfg_pkg::PRBS_SEED;
      sineIdx_q <= 3'h0;
    end
    else if (sampleEn)
    begin
      ramp_q <= (ramp_q == adc_cfg_pkg::RAMP_LAST) ? 12'h000 : ramp_q + 12'h001; // [RULE3]
      toggle_q <= ~toggle_q; // [RULE2]
      prbs_q <= {prbs_q[13:0], prbs_q[14] ^ prbs_q[13]}; // [RULE19]
      sineIdx_q <= sineIdx_q + 3'h1; // [RULE7]
    end
  end

  // Word for the selected code; unused codes give zero
  always_comb
  begin
    case (sel)
      adc_cfg_pkg::PAT_ZEROS: pattern = 12'h000; // [RULE1]
      adc_cfg_pkg::PAT_ONES: pattern = adc_cfg_pkg::ALL_ONES; // [RULE1]
      adc_cfg_pkg::PAT_TOGGLE:
        pattern = toggle_q ? adc_cfg_pkg::TOGGLE_WORD_B : adc_cfg_pkg::TOGGLE_WORD_A; // [RULE2]
      adc_cfg_pkg::PAT_RAMP: pattern = ramp_q; // [RULE3]
      adc_cfg_pkg::PAT_USER: pattern = userWord; // [RULE4]
      adc_cfg_pkg::PAT_DESKEW: pattern = adc_cfg_pkg::DESKEW_WORD; // [RULE5]
      adc_cfg_pkg::PAT_PRBS: pattern = prbs_q[11:0]; // [RULE6]
      adc_cfg_pkg::PAT_SINE: pattern = adc_cfg_pkg::SINE_TABLE[sineIdx_q]; // [RULE7]
      default: pattern = 12'h000;
    endcase
  end

endmodule // test_pattern_gen

`default_nettype wire

// ===== rtl/digital_gain.sv
// Digital gain stage for one channel, 0.5 dB steps with saturation
`timescale 1ns/100ps
`default_nettype none

module digital_gain (
  input wire logic [11:0] sampleIn,
  input wire logic [3:0] code,
  output logic [11:0] sampleOut
);

  logic [3:0] safeCode;
  logic [11:0] factor;
  logic signed [24:0] product;
  logic signed [14:0] scaled;

  // Codes beyond the top step hold at the top step
  assign safeCode = (code > adc_cfg_pkg::GAIN_MAX_CODE) ? adc_cfg_pkg::GAIN_MAX_CODE : code;
  assign factor = adc_cfg_pkg::GAIN_TABLE[safeCode]; // [RULE9]
  assign product = $signed(sampleIn) * $signed({1'b0, factor});
  assign scaled = product[24:10];

  // Clip to the signed 12-bit range
  always_comb
  begin
    if (scaled > 15'sd2047)
      sampleOut = 12'h7ff;
    else if (scaled < -15'sd2048)
      sampleOut = 12'h800;
    else
      sampleOut = scaled[11:0];
  end

endmodule // digital_gain

`default_nettype wire

// ===== verif/adc_cfg_properties.sv
// Port checker for the converter configuration block
`timescale 1ns/100ps
`default_nettype none

module adc_cfg_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleepPin,
  input wire logic [11:0] dataA,
  input wire logic [11:0] dataD,
  input wire logic dataValid,
  input wire logic [3:0] chanSleep,
  input wire logic convStandby,
  input wire logic chipSleep,
  input wire logic lowSpeed
);
  // Completed register write
  wire logic wrDone;
  assign wrDone = psel && penable && pready && pwrite;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read lanes not zero");
  pin_sleeps_a: assert property (sleepPin [*3] |-> chipSleep || convStandby)
    else $error("pin high without sleep");
  chip_mutes_a: assert property (
    chipSleep && $past(chipSleep) && dataValid |-> dataA == 12'h000 && dataD == 12'h000)
    else $error("data during device sleep");
  standby_mutes_a: assert property (
    convStandby && $past(convStandby) && dataValid |-> dataA == 12'h000 && dataD == 12'h000)
    else $error("data during standby");
  chan_d_mute_a: assert property (
    chanSleep[3] && $past(chanSleep[3]) && dataValid |-> dataD == 12'h000)
    else $error("channel D data while asleep");
  speed_by_write_a: assert property (
    $changed(lowSpeed) |-> $past(wrDone) || $past(wrDone, 2))
    else $error("low speed changed without write");
  valid_on_change_a: assert property (
    $changed(dataA) && !$past(wrDone) && !$past(wrDone, 2) |-> dataValid)
    else $error("data changed without valid");
endmodule // adc_cfg_properties

bind adc_test_pattern_gain_power_ctrl adc_cfg_properties i_adc_cfg_properties (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleepPin(sleepPin),
  .dataA(dataA), .dataD(dataD), .dataValid(dataValid), .chanSleep(chanSleep),
  .convStandby(convStandby), .chipSleep(chipSleep), .lowSpeed(lowSpeed));

`default_nettype wire

// ===== verif/apb_host_model.sv
// Host controller model issuing register transfers on APB
`timescale 1ns/100ps
`default_nettype none

module apb_host_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end

  // Setup, access until ready, then release; released lines invert so stale data is not trusted
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d,
    output logic [7:0] q, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule // apb_host_model

`default_nettype wire

// ===== verif/test_adc_test_pattern_gain_power_ctrl.sv
// Self-checking bench for the converter configuration block
`timescale 1ns/100ps
`default_nettype none

module test_adc_test_pattern_gain_power_ctrl;
  // Power cases: expected {device, standby, channels}, pin level, register value
  localparam logic [14:0] PWR [9] = '{15'h0280, 15'h0440, 15'h0820, 15'h1010, 15'h2008,
    15'h5e04, 15'h5f00, 15'h2101, 15'h0001};
  localparam logic [11:0] NVALID [4] = '{12'h010, 12'h010, 12'h008, 12'h004};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rnd = 1'b1;
  logic sleepPin = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, dataValid, convStandby, chipSleep, lowSpeed;
  logic [11:0] paddr, convA, convB, convC, convD, dataA, dataB, dataC, dataD, prev, rdQ, pw;
  logic [31:0] pwdata, prdata;
  logic [7:0] linkTest, v;
  logic [3:0] chanSleep, code;
  logic rdErr;
  int seed = 52826;
  int nFail = 0;
  int nChecks = 0;
  int cnt;

  always #5 clk = ~clk;

  // Fresh random samples while enabled
  always @(posedge clk)
    if (rnd)
    begin
      convA <= 12'($random(seed));
      convB <= 12'($random(seed));
      convC <= 12'($random(seed));
      convD <= 12'($random(seed));
    end

  adc_test_pattern_gain_power_ctrl i_adc_test_pattern_gain_power_ctrl (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .convA(convA),
    .convB(convB), .convC(convC), .convD(convD), .sleepPin(sleepPin), .dataA(dataA),
    .dataB(dataB), .dataC(dataC), .dataD(dataD), .dataValid(dataValid),
    .chanSleep(chanSleep), .convStandby(convStandby), .chipSleep(chipSleep),
    .lowSpeed(lowSpeed), .linkTest(linkTest));

  apb_host_model i_apb_host_model (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    @(posedge clk);
    i_apb_host_model.xfer(1'b1, {2'b00, idx}, d, q, rdErr);
  endtask

  task automatic rd(input logic [7:0] idx);
    logic [7:0] q;
    @(posedge clk);
    i_apb_host_model.xfer(1'b0, {2'b00, idx}, 8'h00, q, rdErr);
    rdQ = {4'h0, q};
  endtask

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Gained value of a 256 input, 0.5 dB per code
  function automatic logic [11:0] gained(input int g);
    int f;
    f = $rtoi(1024.0 * 10.0 ** (g / 40.0) + 0.5);
    return 12'((256 * f) >> 10);
  endfunction

  // Watchdog, several times the expected run length
  initial
  begin
    #400000;
    nFail++;
    wrapUp;
  end

  initial
  begin
    {convA, convB, convC, convD} = 48'h0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, then random writes seen through each field mask
    for (int s = 0; s < adc_cfg_pkg::NUM_SLOTS; s++)
    begin
      rd(adc_cfg_pkg::SLOT_IDX[s]);
      chk("reset value", rdQ, 12'h000);
      v = 8'($random(seed));
      if (s == adc_cfg_pkg::SLOT_CTRL)
        v[adc_cfg_pkg::SOFT_RESET_BIT] = 1'b0;
      wr(adc_cfg_pkg::SLOT_IDX[s], v);
      rd(adc_cfg_pkg::SLOT_IDX[s]);
      chk("readback", rdQ, {4'h0, v & adc_cfg_pkg::SLOT_MASK[s]});
    end
    rd(8'h3f);
    chk("unmapped error", {11'h000, rdErr}, 12'h001);
    chk("unmapped data", rdQ, 12'h000);
    wr(adc_cfg_pkg::IDX_TEST_CTRL, 8'h01);
    rd(adc_cfg_pkg::IDX_POWER_CONTROL);
    chk("soft reset", rdQ, 12'h000);
    $display("register test done");
    // Selector codes 0 to 9 on all channels
    rnd <= 1'b0;
    v = 8'($random(seed));
    wr(adc_cfg_pkg::IDX_USER_WORD_HIGH, v);
    wr(adc_cfg_pkg::IDX_USER_WORD_LOW, 8'h90);
    wr(adc_cfg_pkg::IDX_TEST_CTRL, 8'h02);
    for (int c = 0; c < 10; c++)
    begin
      code = 4'(c);
      wr(adc_cfg_pkg::IDX_TEST_SEL_CH_A_B, {code, code});
      wr(adc_cfg_pkg::IDX_TEST_SEL_CH_C_D, {code, code});
      repeat (4) @(posedge clk);
      prev = dataA;
      @(posedge clk);
      case (c)
        0: chk("normal", dataD, convD);
        1: chk("zeros", dataD, 12'h000);
        2: chk("ones", dataD, 12'hfff);
        3:
        begin
          chk("toggle", dataA ^ prev, 12'hfff);
          chk("toggle word", dataA ^ {6{dataA[11], ~dataA[11]}}, 12'h000);
        end
        4:
        begin
          chk("ramp", dataA, prev + 12'h001);
          cnt = 0;
          while (dataA !== 12'hfff && cnt < 5000)
          begin
            @(posedge clk);
            cnt++;
          end
          @(posedge clk);
          chk("ramp wrap", dataA, 12'h000);
        end
        5: chk("custom", dataD, {v, 4'h9});
        6: chk("deskew", dataD, 12'haaa);
        7: chk("reserved", dataD, 12'h000);
        8: chk("prbs", {1'b0, dataA[11:1]}, {1'b0, prev[10:0]});
        default: chk("sine moves", 12'(dataA != prev), 12'h001);
      endcase
    end
    cnt = 0;
    while (dataA !== 12'h000 && cnt < 16)
    begin
      @(posedge clk);
      cnt++;
    end
    for (int k = 1; k < 8; k++)
    begin
      @(posedge clk);
      chk("sine", dataA, adc_cfg_pkg::SINE_TABLE[k]);
      chk("sine C", dataC, adc_cfg_pkg::SINE_TABLE[k]);
    end
    wr(adc_cfg_pkg::IDX_TEST_SEL_CH_C_D, 8'h22);
    wr(adc_cfg_pkg::IDX_TEST_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk("test off", dataD, convD);
    $display("pattern test done");
    // Gain codes on A, B left raw
    convA <= 12'h100;
    convB <= 12'h100;
    wr(adc_cfg_pkg::IDX_GAIN_ON_A, 8'h02);
    for (int g = 0; g < 16; g++)
    begin
      code = 4'(g);
      wr(adc_cfg_pkg::IDX_GAIN_CH_A_B, {code, code});
      repeat (3) @(posedge clk);
      chk("gain on", dataA, gained(g > 12 ? 12 : g));
      chk("gain off", dataB, 12'h100);
    end
    $display("gain test done");
    // Power bits and pin mapping
    for (int k = 0; k < 9; k++)
    begin
      sleepPin <= PWR[k][8];
      wr(adc_cfg_pkg::IDX_POWER_CONTROL, PWR[k][7:0]);
      repeat (3) @(posedge clk);
      pw = {6'h00, chipSleep, convStandby, chanSleep};
      chk("power", pw, {6'h00, PWR[k][14:9]});
      rd(adc_cfg_pkg::IDX_STATUS);
      chk("status", rdQ, {6'h00, PWR[k][14:9]});
    end
    sleepPin <= 1'b0;
    wr(adc_cfg_pkg::IDX_POWER_CONTROL, 8'h00);
    $display("power test done");
    // Sample rate per divider setting
    for (int d = 0; d < 4; d++)
    begin
      wr(adc_cfg_pkg::IDX_SAMPLE_CLOCK_DIVIDER, {2'(d), 6'h00});
      repeat (4) @(posedge clk);
      cnt = 0;
      repeat (16)
      begin
        @(posedge clk);
        if (dataValid === 1'b1)
          cnt++;
      end
      chk("valid count", 12'(cnt), NVALID[d]);
    end
    v = 8'($random(seed));
    wr(adc_cfg_pkg::IDX_SLOW_RATE_SELECT, 8'h80);
    wr(adc_cfg_pkg::IDX_LINK_TEST_CONTROL, v);
    repeat (2) @(posedge clk);
    chk("low speed", {11'h000, lowSpeed}, 12'h001);
    chk("link test", {4'h0, linkTest}, {4'h0, v});
    $display("rate test done");
    wrapUp;
  end
endmodule // test_adc_test_pattern_gain_power_ctrl

`default_nettype wire
